// >>> verif/flash_programmer_mode_commands_tb_top.sv
// Self-checking bench for the programmer-mode sequencer
`timescale 1ns/1ps
module flash_programmer_mode_commands_tb_top;
  logic SYS_CLK = 1'b0, SYS_RST = 1'b1, fail_req = 1'b0;
  logic CE_N = 1'b1, OE_N = 1'b1, WE_N = 1'b1, FLASH_PROGRAM_GATE = 1'b0;
  logic [17:0] ADDR = 18'h00000, MEM_ADDR, PAGE_WRITE_LOCATION;
  logic [7:0] DATA_IN = 8'h00, DATA_OUT, MEM_RDATA;
  logic [1023:0] PAGE_DATA;
  logic DATA_OE, PAGE_WRITE, MEM_ERASE, MEM_DONE, MEM_FAIL, READY, BUSY;
  int err_total = 0, checks = 0, pw_cnt = 0, er_cnt = 0;
  logic [17:0] row_a [3] = '{18'h00010, 18'h200FF, 18'h3FF00};
  logic [7:0] row_d [3] = '{8'h4A, 8'hA5, 8'h5A};

  initial
  begin
    forever #10 SYS_CLK = ~SYS_CLK;
  end

  fpm_sequencer #(.SETUP_CYC(40), .WRITE_CYC(4), .ERASE_CYC(4)) u_dut
  (
    .SYS_CLK, .SYS_RST, .CE_N, .OE_N, .WE_N, .FLASH_PROGRAM_GATE, .ADDR, .DATA_IN, .DATA_OUT, .DATA_OE,
    .MEM_ADDR, .MEM_RDATA, .PAGE_WRITE, .PAGE_WRITE_LOCATION, .PAGE_DATA, .MEM_ERASE, .MEM_DONE,
    .MEM_FAIL, .READY, .BUSY
  );
  fpm_array_model u_array
  (
    .clk(SYS_CLK), .rst(SYS_RST), .mem_addr(MEM_ADDR), .launch(PAGE_WRITE | MEM_ERASE), .fail_req,
    .mem_rdata(MEM_RDATA), .mem_done(MEM_DONE), .mem_fail(MEM_FAIL)
  );

  always @(posedge SYS_CLK)
  begin
    if (PAGE_WRITE === 1'b1) pw_cnt++;
    if (MEM_ERASE === 1'b1) er_cnt++;
  end

  // ====
  // Compare and bus tasks
  task automatic chk1(input string nm, input logic exp, input logic got);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] %s expected %b seen %b", nm, exp, got);
    end
  endtask
  task automatic chk8(input string nm, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic chk18(input string nm, input logic [17:0] exp, input logic [17:0] got);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Released data bus shows inverse, never the stale byte
  task automatic wr(input logic [7:0] d, input logic [17:0] a, input logic g);
    @(posedge SYS_CLK);
    CE_N <= 1'b0;
    WE_N <= 1'b0;
    ADDR <= a;
    DATA_IN <= d;
    FLASH_PROGRAM_GATE <= g;
    repeat (2) @(posedge SYS_CLK);
    WE_N <= 1'b1;
    repeat (3) @(posedge SYS_CLK);
    CE_N <= 1'b1;
    DATA_IN <= ~d;
  endtask
  task automatic cmd(input logic [7:0] d, input logic g);
    wr(d, 18'h00000, g);
    repeat (1000) @(posedge SYS_CLK);
  endtask
  task automatic look(input int n, input logic [7:0] exp, input string nm);
    @(posedge SYS_CLK);
    CE_N <= 1'b0;
    OE_N <= 1'b0;
    repeat (n) @(posedge SYS_CLK);
    #1;
    chk8(nm, exp, DATA_OUT);
    chk1("drive", 1'b1, DATA_OE);
    @(posedge SYS_CLK);
    CE_N <= 1'b1;
    OE_N <= 1'b1;
  endtask
  task automatic wait_idle;
    for (int i = 0; i < 500 && BUSY !== 1'b0; i++)
      @(posedge SYS_CLK);
    #1;
    chk1("busy end", 1'b0, BUSY);
  endtask
  task automatic stat(input logic [7:0] exp);
    cmd(8'h71, 1'b0);
    cmd(8'h71, 1'b0);
    look(2, exp, "status");
  endtask
  // Last eight bytes padded as unused locations
  task automatic prog(input logic [17:0] pg, input logic [7:0] poll_exp, input logic [7:0] st_exp);
    int n;
    n = pw_cnt;
    cmd(8'h40, 1'b1);
    for (int k = 0; k < 128; k++)
      wr(k < 120 ? 8'(k) : 8'hFF, k == 0 ? pg : 18'h3FFFF, 1'b1);
    look(2, 8'h00, "poll busy");
    chk1("busy", 1'b1, BUSY);
    chk1("launch", 1'b1, pw_cnt == n + 1);
    chk18("location", pg, PAGE_WRITE_LOCATION);
    for (int k = 0; k < 128; k++)
      chk8("page byte", k < 120 ? 8'(k) : 8'hFF, PAGE_DATA[8*k +: 8]);
    wait_idle();
    look(2, poll_exp, "poll end");
    repeat (50) @(posedge SYS_CLK);
    look(2, poll_exp, "poll hold");
    stat(st_exp);
  endtask
  task automatic erase(input logic g, input logic [7:0] poll_exp, input logic [7:0] st_exp);
    int n;
    n = er_cnt;
    cmd(8'h20, g);
    cmd(8'h20, g);
    chk1("erase launch", g, er_cnt == n + 1);
    if (g)
    begin
      wait_idle();
      look(2, poll_exp, "erase poll");
      stat(st_exp);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ====
  // Sequence
  initial
  begin
    repeat (12) @(posedge SYS_CLK);
    chk8("reset out", 8'h00, DATA_OUT);
    SYS_RST <= 1'b0;
    wr(8'h20, 18'h00000, 1'b1);
    wr(8'h20, 18'h00000, 1'b1);
    #1;
    chk1("ready early", 1'b0, READY);
    repeat (40) @(posedge SYS_CLK);
    #1;
    chk1("ready", 1'b1, READY);
    chk1("early erase", 1'b0, er_cnt != 0);
    $display("test setup done");
    cmd(8'h00, 1'b0);
    foreach (row_a[i])
    begin
      @(posedge SYS_CLK);
      ADDR <= row_a[i];
      look(1005, row_d[i], "read");
    end
    $display("test read done");
    prog(18'h01080, 8'hC0, 8'h00);
    $display("test program done");
    prog(18'h00240, 8'h80, 8'hA1);
    $display("test bad page done");
    erase(1'b0, 8'h00, 8'h00);
    erase(1'b1, 8'hC0, 8'h00);
    @(posedge SYS_CLK);
    fail_req <= 1'b1;
    erase(1'b1, 8'h80, 8'h90);
    fail_req <= 1'b0;
    $display("test erase done");
    cmd(8'h55, 1'b0);
    stat(8'hC0);
    // Second erase cycle with a wrong code aborts and flags a command error
    cmd(8'h20, 1'b1);
    cmd(8'h00, 1'b0);
    chk1("erase abort", 1'b1, er_cnt == 2);
    stat(8'hC0);
    $display("test command error done");
    @(posedge SYS_CLK);
    SYS_RST <= 1'b1;
    repeat (2) @(posedge SYS_CLK);
    #1;
    chk1("reset ready", 1'b0, READY);
    chk8("reset data", 8'h00, DATA_OUT);
    @(posedge SYS_CLK);
    SYS_RST <= 1'b0;
    repeat (45) @(posedge SYS_CLK);
    #1;
    chk1("ready again", 1'b1, READY);
    $display("test reset done");
    end_of_test();
  end

  initial
  begin
    repeat (60000) @(posedge SYS_CLK);
    err_total++;
    end_of_test();
  end
endmodule

// >>> verif/fpm_array_model.sv
// Behavioural flash array behind the sequencer
`timescale 1ns/1ps
module fpm_array_model
#(
  parameter int DONE_DLY = 20
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [17:0] mem_addr,
  input wire logic launch,
  input wire logic fail_req,
  output logic [7:0] mem_rdata,
  output logic mem_done,
  output logic mem_fail
);
  int cnt_reg;
  // ====
  // Read path: address-derived pattern
  assign mem_rdata = mem_addr[7:0] ^ 8'h5A;
  // ====
  // Operation timer, scaled far below real write time
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cnt_reg <= 0;
      mem_done <= 1'b0;
      mem_fail <= 1'b0;
    end
    else if (launch)
    begin
      cnt_reg <= DONE_DLY;
      mem_done <= 1'b0;
    end
    else if (cnt_reg == 1)
    begin
      cnt_reg <= 0;
      mem_done <= 1'b1;
      mem_fail <= fail_req;
    end
    else if (cnt_reg > 1)
      cnt_reg <= cnt_reg - 1;
  end
endmodule

// >>> verif/fpm_sequencer_chk.sv
// Port assertions for the programmer-mode sequencer
`timescale 1ns/1ps
module fpm_sequencer_chk
(
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  input wire logic CE_N,
  input wire logic OE_N,
  input wire logic WE_N,
  input wire logic [17:0] ADDR,
  input wire logic [7:0] DATA_OUT,
  input wire logic DATA_OE,
  input wire logic [17:0] MEM_ADDR,
  input wire logic PAGE_WRITE,
  input wire logic [17:0] PAGE_WRITE_LOCATION,
  input wire logic MEM_ERASE,
  input wire logic READY,
  input wire logic BUSY
);
  // ====
  // Properties
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SYS_RST);
  a_drive_on_read: assert property (DATA_OE == (!CE_N && !OE_N && WE_N))
    else $error("data drive not decoded from strobes");
  a_quiet_in_setup: assert property (!READY |-> !PAGE_WRITE && !MEM_ERASE)
    else $error("launch before setup ended");
  a_page_one_pulse: assert property (PAGE_WRITE |=> !PAGE_WRITE)
    else $error("page launch longer than one cycle");
  a_erase_one_pulse: assert property (MEM_ERASE |=> !MEM_ERASE)
    else $error("erase launch longer than one cycle");
  a_launch_sets_busy: assert property (PAGE_WRITE || MEM_ERASE |-> ##[0:1] BUSY)
    else $error("busy missing after launch");
  a_busy_min_span: assert property ($rose(BUSY) |=> BUSY[*3])
    else $error("busy ended too soon");
  a_addr_follows: assert property (!$past(SYS_RST) |-> MEM_ADDR == $past(ADDR))
    else $error("array address not one cycle behind");
  a_loc_held_busy: assert property (BUSY && $past(BUSY) |-> $stable(PAGE_WRITE_LOCATION))
    else $error("page location moved while busy");
  a_poll_zero_busy: assert property ($past(BUSY) && $past(DATA_OE) && BUSY |-> DATA_OUT == 8'h00)
    else $error("poll byte not zero while busy");
  c_page: cover property (PAGE_WRITE);
  c_erase: cover property (MEM_ERASE);
  c_done: cover property ($fell(BUSY));
endmodule

bind fpm_sequencer fpm_sequencer_chk u_chk
(
  .SYS_CLK, .SYS_RST, .CE_N, .OE_N, .WE_N, .ADDR, .DATA_OUT, .DATA_OE, .MEM_ADDR,
  .PAGE_WRITE, .PAGE_WRITE_LOCATION, .MEM_ERASE, .READY, .BUSY
);

// >>> verilog/fpm_defines.svh
// Constants for the flash programmer-mode command sequencer
`ifndef FPM_DEFINES_SVH
`define FPM_DEFINES_SVH

`define FPM_CMD_READ 8'h00
`define FPM_CMD_PROG 8'h40
`define FPM_CMD_ERASE 8'h20
`define FPM_CMD_STAT 8'h71
`define FPM_FILL_BYTE 8'hFF
`define FPM_PAGE_BYTES 8'h80
`define FPM_PAGE_LOW_A 8'h00
`define FPM_PAGE_LOW_B 8'h80
`define FPM_CLK_MHZ 50
`define FPM_SETUP_MS 10
`define FPM_SETUP_CYC (`FPM_SETUP_MS * 1000 * `FPM_CLK_MHZ)
`define FPM_ACCESS_US 20
`define FPM_ACCESS_CYC (`FPM_ACCESS_US * `FPM_CLK_MHZ)
`define FPM_WRITE_MIN_MS 1
`define FPM_WRITE_CYC (`FPM_WRITE_MIN_MS * 1000 * `FPM_CLK_MHZ)
`define FPM_ERASE_MIN_MS 100
`define FPM_ERASE_CYC (`FPM_ERASE_MIN_MS * 1000 * `FPM_CLK_MHZ)
`define FPM_STAT_ABN_BIT 7
`define FPM_STAT_CMD_BIT 6
`define FPM_STAT_PRG_BIT 5
`define FPM_STAT_ERS_BIT 4
`define FPM_STAT_CNT_BIT 1
`define FPM_STAT_ADR_BIT 0

`endif

// >>> verilog/fpm_pkg.sv
// Types for the flash programmer-mode command sequencer
package fpm_pkg;

  typedef enum logic [2:0]
  {
    FPM_SETUP = 3'h0,
    FPM_IDLE = 3'h1,
    FPM_LOAD = 3'h3,
    FPM_BUSY = 3'h2,
    FPM_ERASE2 = 3'h6,
    FPM_STAT2 = 3'h7
  } fpm_state_t;

  typedef enum logic [1:0]
  {
    FPM_OUT_READ = 2'h0,
    FPM_OUT_POLL = 2'h1,
    FPM_OUT_STAT = 2'h2
  } fpm_out_t;

endpackage

// >>> verilog/fpm_sequencer.sv
// Programmer-mode command sequencer for the on-chip flash
`timescale 1ns/1ps
`include "fpm_defines.svh"
module fpm_sequencer
#(
  parameter int SETUP_CYC = `FPM_SETUP_CYC,
  parameter int WRITE_CYC = `FPM_WRITE_CYC,
  parameter int ERASE_CYC = `FPM_ERASE_CYC
)
(
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  input wire logic CE_N,
  input wire logic OE_N,
  input wire logic WE_N,
  input wire logic FLASH_PROGRAM_GATE,
  input wire logic [17:0] ADDR,
  input wire logic [7:0] DATA_IN,
  output logic [7:0] DATA_OUT,
  output logic DATA_OE,
  output logic [17:0] MEM_ADDR,
  input wire logic [7:0] MEM_RDATA,
  output logic PAGE_WRITE,
  output logic [17:0] PAGE_WRITE_LOCATION,
  output logic [1023:0] PAGE_DATA,
  output logic MEM_ERASE,
  input wire logic MEM_DONE,
  input wire logic MEM_FAIL,
  output logic READY,
  output logic BUSY
);
  import fpm_pkg::*;

  localparam int ACCESS_CYC = `FPM_ACCESS_CYC;

  logic rd_active;
  logic wr_pulse;
  logic [17:0] wr_addr;
  logic [7:0] wr_data;
  fpm_state_t state_reg;
  fpm_out_t out_sel_reg;
  logic [31:0] timer_reg;
  logic [7:0] count_reg;
  logic [7:0] page_buf [0:127];
  logic [7:0] status_reg;
  logic end_ident_line_reg;
  logic end_status_line_reg;
  logic is_erase_reg;
  logic [17:0] read_location_reg;
  logic [7:0] read_data_reg;
  logic [10:0] access_reg;

  // ==========================================================
  // Strobe decode
  fpm_strobe_decode u_decode
  (
    .clk(SYS_CLK),
    .rst(SYS_RST),
    .ce_n(CE_N),
    .oe_n(OE_N),
    .we_n(WE_N),
    .addr(ADDR),
    .din(DATA_IN),
    .rd_active(rd_active),
    .wr_pulse(wr_pulse),
    .wr_addr(wr_addr),
    .wr_data(wr_data)
  );

  function automatic logic page_aligned(input logic [17:0] a);
    page_aligned = (a[7:0] == `FPM_PAGE_LOW_A) || (a[7:0] == `FPM_PAGE_LOW_B);
  endfunction

  // ==========================================================
  // Command state machine
  // Busy states ignore writes: the programmer must not issue them then
  always_ff @(posedge SYS_CLK)
  begin
    if (SYS_RST)
    begin
      state_reg <= FPM_SETUP;
      timer_reg <= 32'h00000000;
      count_reg <= 8'h00;
      is_erase_reg <= 1'b0;
    end
    else
    begin
      unique case (state_reg)
        FPM_SETUP:
        begin
          if (timer_reg >= 32'(SETUP_CYC - 1))
          begin
            state_reg <= FPM_IDLE;
          end
          else
          begin
            timer_reg <= timer_reg + 32'h00000001;
          end
        end
        FPM_IDLE:
        begin
          timer_reg <= 32'h00000000;
          count_reg <= 8'h00;
          if (wr_pulse)
          begin
            if (wr_data == `FPM_CMD_PROG && FLASH_PROGRAM_GATE)
            begin
              state_reg <= FPM_LOAD;
            end
            else if (wr_data == `FPM_CMD_ERASE && FLASH_PROGRAM_GATE)
            begin
              state_reg <= FPM_ERASE2;
            end
            else if (wr_data == `FPM_CMD_STAT)
            begin
              state_reg <= FPM_STAT2;
            end
          end
        end
        FPM_LOAD:
        begin
          if (wr_pulse)
          begin
            count_reg <= count_reg + 8'h01;
            if (count_reg == `FPM_PAGE_BYTES - 8'h01)
            begin
              state_reg <= FPM_BUSY;
              is_erase_reg <= 1'b0;
            end
          end
        end
        FPM_ERASE2:
        begin
          if (wr_pulse)
          begin
            state_reg <= (wr_data == `FPM_CMD_ERASE) ? FPM_BUSY : FPM_IDLE;
            is_erase_reg <= 1'b1;
          end
        end
        FPM_STAT2:
        begin
          if (wr_pulse)
          begin
            state_reg <= FPM_IDLE;
          end
        end
        FPM_BUSY:
        begin
          // Chip strobe plays no part here: work continues while deselected
          timer_reg <= timer_reg + 32'h00000001;
          if (MEM_DONE && timer_reg >= 32'(is_erase_reg ? ERASE_CYC : WRITE_CYC))
          begin
            state_reg <= FPM_IDLE;
          end
        end
        default:
        begin
          state_reg <= FPM_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Page buffer and page address
  always_ff @(posedge SYS_CLK)
  begin
    if (state_reg == FPM_LOAD && wr_pulse)
    begin
      page_buf[count_reg[6:0]] <= wr_data;
    end
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (SYS_RST)
    begin
      PAGE_WRITE_LOCATION <= 18'h00000;
    end
    else if (state_reg == FPM_LOAD && wr_pulse && count_reg == 8'h00)
    begin
      PAGE_WRITE_LOCATION <= wr_addr;
    end
  end

  always_comb
  begin
    for (int i = 0; i < 128; i++)
    begin
      PAGE_DATA[i * 8 +: 8] = page_buf[i];
    end
  end

  // One-cycle launch strobes toward the array
  always_ff @(posedge SYS_CLK)
  begin
    if (SYS_RST)
    begin
      PAGE_WRITE <= 1'b0;
      MEM_ERASE <= 1'b0;
    end
    else
    begin
      PAGE_WRITE <= state_reg == FPM_LOAD && wr_pulse && count_reg == `FPM_PAGE_BYTES - 8'h01;
      MEM_ERASE <= state_reg == FPM_ERASE2 && wr_pulse && wr_data == `FPM_CMD_ERASE;
    end
  end

  // ==========================================================
  // Status flags
  always_ff @(posedge SYS_CLK)
  begin
    if (SYS_RST)
    begin
      status_reg <= 8'h00;
      end_ident_line_reg <= 1'b0;
      end_status_line_reg <= 1'b0;
    end
    else if (wr_pulse && state_reg != FPM_SETUP && state_reg != FPM_BUSY)
    begin
      // Each command write starts fresh polling information
      end_ident_line_reg <= 1'b0;
      end_status_line_reg <= 1'b0;
      if (state_reg == FPM_IDLE)
      begin
        status_reg <= (wr_data == `FPM_CMD_STAT) ? status_reg : 8'h00;
        if (wr_data != `FPM_CMD_READ && wr_data != `FPM_CMD_PROG && wr_data != `FPM_CMD_ERASE
            && wr_data != `FPM_CMD_STAT)
        begin
          status_reg[`FPM_STAT_CMD_BIT] <= 1'b1;
          status_reg[`FPM_STAT_ABN_BIT] <= 1'b1;
        end
      end
      else if (state_reg == FPM_LOAD && count_reg == 8'h00 && !page_aligned(wr_addr))
      begin
        status_reg[`FPM_STAT_ADR_BIT] <= 1'b1;
        status_reg[`FPM_STAT_PRG_BIT] <= 1'b1;
      end
      else if (state_reg == FPM_ERASE2 && wr_data != `FPM_CMD_ERASE)
      begin
        status_reg[`FPM_STAT_CMD_BIT] <= 1'b1;
        status_reg[`FPM_STAT_ABN_BIT] <= 1'b1;
      end
    end
    else if (state_reg == FPM_BUSY && MEM_DONE && timer_reg >= 32'(is_erase_reg ? ERASE_CYC : WRITE_CYC))
    begin
      // Normal end only when no error was flagged on the way
      end_ident_line_reg <= 1'b1;
      end_status_line_reg <= !MEM_FAIL && status_reg == 8'h00;
      if (MEM_FAIL || status_reg != 8'h00)
      begin
        status_reg[`FPM_STAT_ABN_BIT] <= 1'b1;
        status_reg[is_erase_reg ? `FPM_STAT_ERS_BIT : `FPM_STAT_PRG_BIT] <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Output selection and read path
  always_ff @(posedge SYS_CLK)
  begin
    if (SYS_RST)
    begin
      out_sel_reg <= FPM_OUT_READ;
    end
    else if (state_reg == FPM_IDLE && wr_pulse)
    begin
      out_sel_reg <= (wr_data == `FPM_CMD_READ) ? FPM_OUT_READ : FPM_OUT_POLL;
    end
    else if (state_reg == FPM_STAT2 && wr_pulse)
    begin
      out_sel_reg <= (wr_data == `FPM_CMD_STAT) ? FPM_OUT_STAT : FPM_OUT_POLL;
    end
  end

  // Access timer restarts on any address change; data is held until it expires
  always_ff @(posedge SYS_CLK)
  begin
    if (SYS_RST)
    begin
      read_location_reg <= 18'h00000;
      access_reg <= 11'h000;
      read_data_reg <= 8'h00;
    end
    else
    begin
      read_location_reg <= ADDR;
      if (ADDR != read_location_reg)
      begin
        access_reg <= 11'h000;
      end
      else if (access_reg < 11'(ACCESS_CYC - 1))
      begin
        access_reg <= access_reg + 11'h001;
      end
      else
      begin
        read_data_reg <= MEM_RDATA;
      end
    end
  end

  assign MEM_ADDR = read_location_reg;

  always_ff @(posedge SYS_CLK)
  begin
    if (SYS_RST)
    begin
      DATA_OUT <= 8'h00;
    end
    else
    begin
      unique case (out_sel_reg)
        FPM_OUT_READ: DATA_OUT <= read_data_reg;
        FPM_OUT_STAT: DATA_OUT <= status_reg;
        FPM_OUT_POLL: DATA_OUT <= {end_ident_line_reg, end_status_line_reg, 6'h00};
        default: DATA_OUT <= 8'h00;
      endcase
    end
  end

  // Only the data drivers follow the chip strobe
  assign DATA_OE = rd_active;
  assign READY = state_reg != FPM_SETUP;
  assign BUSY = state_reg == FPM_BUSY;

endmodule

// >>> verilog/fpm_strobe_decode.sv
// Strobe decoder: read level and write-strobe rising edge capture
`timescale 1ns/1ps
module fpm_strobe_decode
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic [17:0] addr,
  input wire logic [7:0] din,
  output logic rd_active,
  output logic wr_pulse,
  output logic [17:0] wr_addr,
  output logic [7:0] wr_data
);

  logic we_n_reg;
  logic ce_n_reg;
  logic [17:0] addr_reg;
  logic [7:0] din_reg;

  // ==========================================================
  // Cycle decode
  assign rd_active = !ce_n && !oe_n && we_n;

  // ==========================================================
  // Write capture
  // Address and data sampled one cycle behind to meet the edge
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      we_n_reg <= 1'b1;
      ce_n_reg <= 1'b1;
      addr_reg <= 18'h00000;
      din_reg <= 8'h00;
    end
    else
    begin
      we_n_reg <= we_n;
      ce_n_reg <= ce_n;
      addr_reg <= addr;
      din_reg <= din;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wr_pulse <= 1'b0;
      wr_addr <= 18'h00000;
      wr_data <= 8'h00;
    end
    else
    begin
      wr_pulse <= we_n && !we_n_reg && !ce_n_reg && oe_n;
      if (we_n && !we_n_reg && !ce_n_reg)
      begin
        wr_addr <= addr_reg;
        wr_data <= din_reg;
      end
    end
  end

endmodule
